/* core/plf_regs.vh */
// register map, field layout and codes of the packet filter
`ifndef PLF_REGS_VH
`define PLF_REGS_VH
`define PLF_NUM_ENT 8
`define PLF_WORDS 10
`define PLF_NUM_PORTS 10
`define PLF_A_STAGE_END 8'h28
`define PLF_A_CMD 8'h28
`define PLF_A_STATUS 8'h2c
`define PLF_A_PORT_DIS 8'h30
`define PLF_A_BIND0 8'h34
`define PLF_A_BIND1 8'h38
`define PLF_A_COUNT 8'h3c
`define PLF_A_RANGE_TOP 2'h1
`define PLF_C_OP 5:4
`define PLF_C_IDX 2:0
`define PLF_OP_WRITE 2'h1
`define PLF_OP_DEL 2'h2
`define PLF_OP_DEL_LIST 2'h3
`define PLF_F_IPV4 0
`define PLF_F_ACT 2:1
`define PLF_F_LIST 3
`define PLF_F_SEQ 11:4
`define PLF_F_A_EN 12
`define PLF_F_B_EN 13
`define PLF_F_ETY_EN 14
`define PLF_F_VLAN_EN 15
`define PLF_F_PRI_EN 16
`define PLF_F_PROTO_EN 17
`define PLF_F_SPM 19:18
`define PLF_F_DPM 21:20
`define PLF_F_FLG_EN 22
`define PLF_F_TOSM 24:23
`define PLF_F_ICT_EN 25
`define PLF_F_ICC_EN 26
`define PLF_F_ETY 15:0
`define PLF_F_VLAN 27:16
`define PLF_F_PRI 30:28
`define PLF_F_PRIM 2:0
`define PLF_F_PROTO 7:0
`define PLF_F_FLG 15:8
`define PLF_F_TOS 21:16
`define PLF_F_PREC 18:16
`define PLF_F_ICT 29:22
`define PLF_F_ICC 7:0
`define PLF_F_SRNG 10:8
`define PLF_F_DRNG 13:11
`define PLF_F_SPORT 15:0
`define PLF_F_DPORT 31:16
`define PLF_F_HI16 31:16
`define PLF_F_LO16 15:0
`define PLF_ACT_PERMIT 2'h0
`define PLF_ACT_DENY 2'h1
`define PLF_ACT_SHUT 2'h2
`define PLF_PM_SINGLE 2'h1
`define PLF_PM_RANGE 2'h2
`define PLF_TOS_DSCP 2'h1
`define PLF_TOS_PREC 2'h2
`define PLF_PROTO_ICMP 8'h01
`define PLF_PROTO_TCP 8'h06
`define PLF_PROTO_UDP 8'h11
`endif

/* core/plf_filter.v */
// ingress l2/ipv4 packet filter with apb configuration
//
// Behaviour
// - each entry has a sequence number; lowest value wins, 1 is highest
// - a frame matching a permit entry goes on to forwarding
// - a frame matching a deny entry is discarded
// - shutdown discards and disables the port until software re-enables it
// - source mac is any or address under mask
// - destination mac is any or address under mask
// - ethertype is any or one exact value
// - vlan id is any or one exact value
// - priority bits are any or value under mask
// - edit or delete of an entry in a bound list is rejected
// - adding an entry to a bound list is rejected
// - a bound list cannot be deleted
// - each list reports its entry count and bound ports; applies only there
// - ipv4 entries match protocol and masked source and destination address
// - l4 port single or range criteria apply only for tcp or udp
// - tcp flags criterion applies only for tcp entries
// - type of service matched as dscp or as precedence
// - icmp type and code apply only for icmp entries
// - eight shared port ranges each for tcp and udp
//
// Design decisions made here: the register offsets and the APB register port.
`include "plf_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module plf_filter (
    // clock and reset
    input wire clk_sys_in,
    input wire rst_n_in,
    // apb slave
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output reg pready_out,
    output reg pslverr_out,
    // received frame header
    input wire frm_valid_in,
    input wire [3:0] frm_port_in,
    input wire [47:0] frm_smac_in,
    input wire [47:0] frm_dmac_in,
    input wire [15:0] frm_etype_in,
    input wire [11:0] frm_vlan_in,
    input wire [2:0] frm_pri_in,
    input wire frm_ipv4_in,
    input wire [7:0] frm_proto_in,
    input wire [31:0] frm_sip_in,
    input wire [31:0] frm_dip_in,
    input wire [15:0] frm_sport_in,
    input wire [15:0] frm_dport_in,
    input wire [7:0] frm_flags_in,
    input wire [7:0] frm_tos_in,
    input wire [7:0] frm_icmp_type_in,
    input wire [7:0] frm_icmp_code_in,
    output reg frm_ready_out,
    // decision and port state
    output reg dec_valid_out,
    output reg dec_forward_out,
    output reg dec_drop_out,
    output reg [9:0] port_disabled_out
);
    localparam ST_IDLE = 3'b001;
    localparam ST_SCAN = 3'b010;
    localparam ST_DONE = 3'b100;

    function [6:0] ent_base;
        input [2:0] idx;
        ent_base = {4'h0, idx} * 7'd10;
    endfunction

    function mask_eq;
        input [47:0] val;
        input [47:0] cfg;
        input [47:0] msk;
        mask_eq = ((val ^ cfg) & msk) == 48'h0;
    endfunction
    function port_ok;
        input [1:0] mode;
        input [15:0] port;
        input [15:0] single;
        input [31:0] rng;
        case (mode)
            `PLF_PM_SINGLE: port_ok = port == single;
            `PLF_PM_RANGE: port_ok = port >= rng[`PLF_F_LO16] && port <= rng[`PLF_F_HI16];
            default: port_ok = 1'b1;
        endcase
    endfunction
    reg [31:0] ent_mem [0:79];
    reg [31:0] stage_reg [0:9];
    reg [31:0] rng_mem [0:15];
    reg [7:0] valid_reg;
    reg [9:0] bind0_reg;
    reg [9:0] bind1_reg;
    reg reject_reg;
    reg [2:0] state_reg;
    reg [2:0] scan_reg;
    reg best_hit_reg;
    reg [7:0] best_seq_reg;
    reg [1:0] best_act_reg;
    reg [3:0] f_port;
    reg [47:0] f_smac;
    reg [47:0] f_dmac;
    reg [15:0] f_etype;
    reg [11:0] f_vlan;
    reg [2:0] f_pri;
    reg f_ipv4;
    reg [7:0] f_proto;
    reg [31:0] f_sip;
    reg [31:0] f_dip;
    reg [15:0] f_sport;
    reg [15:0] f_dport;
    reg [7:0] f_flags;
    reg [7:0] f_tos;
    reg [7:0] f_ict;
    reg [7:0] f_icc;
    integer i;
    // apb decode
    wire access = psel_in & penable_in & ~pready_out;
    wire wr_go = psel_in & penable_in & pready_out & pwrite_in;
    reg [31:0] rd_data;
    reg rd_err;
    reg [3:0] cnt0;
    reg [3:0] cnt1;
    always @* begin
        cnt0 = 4'h0;
        cnt1 = 4'h0;
        for (i = 0; i < `PLF_NUM_ENT; i = i + 1) begin
            if (valid_reg[i]) begin
                if (ent_mem[ent_base(i[2:0])][`PLF_F_LIST])
                    cnt1 = cnt1 + 4'h1;
                else
                    cnt0 = cnt0 + 4'h1;
            end
        end
    end

    always @* begin
        rd_data = 32'h0;
        rd_err = 1'b0;
        if (paddr_in[1:0] != 2'h0) begin
            rd_err = 1'b1;
        end else if (paddr_in < `PLF_A_STAGE_END) begin
            rd_data = stage_reg[paddr_in[5:2]];
        end else if (paddr_in[7:6] == `PLF_A_RANGE_TOP) begin
            rd_data = rng_mem[paddr_in[5:2]];
        end else begin
            case (paddr_in)
                `PLF_A_CMD: rd_data = 32'h0;
                `PLF_A_STATUS: rd_data = {30'h0, ~state_reg[0], reject_reg};
                `PLF_A_PORT_DIS: rd_data = {22'h0, port_disabled_out};
                `PLF_A_BIND0: rd_data = {22'h0, bind0_reg};
                `PLF_A_BIND1: rd_data = {22'h0, bind1_reg};
                `PLF_A_COUNT: rd_data = {24'h0, cnt1, cnt0};
                default: rd_err = 1'b1;
            endcase
        end
    end

    // command checks against list binding
    wire [1:0] cmd_op = pwdata_in[`PLF_C_OP];
    wire [2:0] cmd_idx = pwdata_in[`PLF_C_IDX];
    wire [6:0] cmd_base = ent_base(cmd_idx);
    wire old_list = ent_mem[cmd_base][`PLF_F_LIST];
    wire new_list = stage_reg[0][`PLF_F_LIST];
    wire old_bound = valid_reg[cmd_idx] & (old_list ? |bind1_reg : |bind0_reg);
    wire new_bound = new_list ? |bind1_reg : |bind0_reg;
    wire list_bound = cmd_idx[0] ? |bind1_reg : |bind0_reg;
    wire cmd_go = wr_go & (paddr_in == `PLF_A_CMD);
    // entry under scan
    wire [6:0] sb = ent_base(scan_reg);
    wire [31:0] w0 = ent_mem[sb];
    wire [31:0] w3 = ent_mem[sb + 7'd3];
    wire [31:0] w6 = ent_mem[sb + 7'd6];
    wire [31:0] w7 = ent_mem[sb + 7'd7];
    wire [31:0] w8 = ent_mem[sb + 7'd8];
    wire [31:0] w9 = ent_mem[sb + 7'd9];
    wire [47:0] a_val = {w3[`PLF_F_LO16], ent_mem[sb + 7'd1]};
    wire [47:0] a_msk = {w3[`PLF_F_HI16], ent_mem[sb + 7'd2]};
    wire [47:0] b_val = {w6[`PLF_F_LO16], ent_mem[sb + 7'd4]};
    wire [47:0] b_msk = {w6[`PLF_F_HI16], ent_mem[sb + 7'd5]};
    wire [7:0] e_proto = w7[`PLF_F_PROTO];
    wire e_tcp = w0[`PLF_F_PROTO_EN] & (e_proto == `PLF_PROTO_TCP);
    wire e_udp = w0[`PLF_F_PROTO_EN] & (e_proto == `PLF_PROTO_UDP);
    wire e_icmp = w0[`PLF_F_PROTO_EN] & (e_proto == `PLF_PROTO_ICMP);
    wire [31:0] srng = rng_mem[{e_udp, w8[`PLF_F_SRNG]}];
    wire [31:0] drng = rng_mem[{e_udp, w8[`PLF_F_DRNG]}];
    wire [9:0] port_sel = 10'h1 << f_port;
    wire [9:0] e_bind = w0[`PLF_F_LIST] ? bind1_reg : bind0_reg;
    wire bound_here = |(e_bind & port_sel);
    wire mac_ok = (~w0[`PLF_F_A_EN] | mask_eq(f_smac, a_val, a_msk))
        & (~w0[`PLF_F_B_EN] | mask_eq(f_dmac, b_val, b_msk))
        & (~w0[`PLF_F_ETY_EN] | (f_etype == w7[`PLF_F_ETY]))
        & (~w0[`PLF_F_VLAN_EN] | (f_vlan == w7[`PLF_F_VLAN]))
        & (~w0[`PLF_F_PRI_EN] | (((f_pri ^ w7[`PLF_F_PRI]) & w8[`PLF_F_PRIM]) == 3'h0));
    reg tos_ok;
    always @* begin
        case (w0[`PLF_F_TOSM])
            `PLF_TOS_DSCP: tos_ok = f_tos[7:2] == w7[`PLF_F_TOS];
            `PLF_TOS_PREC: tos_ok = f_tos[7:5] == w7[`PLF_F_PREC];
            default: tos_ok = 1'b1;
        endcase
    end
    wire l4_on = e_tcp | e_udp;
    wire ip_ok = f_ipv4
        & (~w0[`PLF_F_PROTO_EN] | (f_proto == e_proto))
        & (~w0[`PLF_F_A_EN] | mask_eq({16'h0, f_sip}, a_val, a_msk))
        & (~w0[`PLF_F_B_EN] | mask_eq({16'h0, f_dip}, b_val, b_msk))
        & (~l4_on | port_ok(w0[`PLF_F_SPM], f_sport, w9[`PLF_F_SPORT], srng))
        & (~l4_on | port_ok(w0[`PLF_F_DPM], f_dport, w9[`PLF_F_DPORT], drng))
        & (~(e_tcp & w0[`PLF_F_FLG_EN]) | ((f_flags & w7[`PLF_F_FLG]) == w7[`PLF_F_FLG]))
        & tos_ok
        & (~(e_icmp & w0[`PLF_F_ICT_EN]) | (f_ict == w7[`PLF_F_ICT]))
        & (~(e_icmp & w0[`PLF_F_ICC_EN]) | (f_icc == w8[`PLF_F_ICC]));

    wire ent_hit = valid_reg[scan_reg] & bound_here & (w0[`PLF_F_IPV4] ? ip_ok : mac_ok);
    wire better = ~best_hit_reg | (w0[`PLF_F_SEQ] < best_seq_reg);

    // apb responder
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0;
        end else begin
            pready_out <= access;
            pslverr_out <= access & rd_err;
            if (access)
                prdata_out <= rd_data;
        end
    end

    // configuration registers and entry commands
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (i = 0; i < `PLF_WORDS; i = i + 1)
                stage_reg[i] <= 32'h0;
            for (i = 0; i < 16; i = i + 1)
                rng_mem[i] <= 32'h0;
            valid_reg <= 8'h0;
            bind0_reg <= 10'h0;
            bind1_reg <= 10'h0;
            reject_reg <= 1'b0;
        end else if (wr_go && !pslverr_out) begin
            if (paddr_in < `PLF_A_STAGE_END)
                stage_reg[paddr_in[5:2]] <= pwdata_in;
            if (paddr_in[7:6] == `PLF_A_RANGE_TOP)
                rng_mem[paddr_in[5:2]] <= pwdata_in;
            if (paddr_in == `PLF_A_BIND0)
                bind0_reg <= pwdata_in[9:0];
            if (paddr_in == `PLF_A_BIND1)
                bind1_reg <= pwdata_in[9:0];
            if (cmd_go) begin
                case (cmd_op)
                    `PLF_OP_WRITE: begin
                        if (old_bound | new_bound) begin
                            reject_reg <= 1'b1;
                        end else begin
                            reject_reg <= 1'b0;
                            valid_reg[cmd_idx] <= 1'b1;
                        end
                    end
                    `PLF_OP_DEL: begin
                        reject_reg <= old_bound;
                        if (!old_bound)
                            valid_reg[cmd_idx] <= 1'b0;
                    end
                    `PLF_OP_DEL_LIST: begin
                        reject_reg <= list_bound;
                        for (i = 0; i < `PLF_NUM_ENT; i = i + 1)
                            if (!list_bound && ent_mem[ent_base(i[2:0])][`PLF_F_LIST] == cmd_idx[0])
                                valid_reg[i] <= 1'b0;
                    end
                    default: reject_reg <= reject_reg;
                endcase
            end
        end
    end
    // entry storage, no reset needed: guarded by valid bits
    always @(posedge clk_sys_in) begin
        if (cmd_go && !pslverr_out && cmd_op == `PLF_OP_WRITE && !(old_bound | new_bound))
            for (i = 0; i < `PLF_WORDS; i = i + 1)
                ent_mem[cmd_base + i[6:0]] <= stage_reg[i];
    end
    // frame capture
    always @(posedge clk_sys_in) begin
        if (frm_valid_in && frm_ready_out) begin
            f_port <= frm_port_in;
            f_smac <= frm_smac_in;
            f_dmac <= frm_dmac_in;
            f_etype <= frm_etype_in;
            f_vlan <= frm_vlan_in;
            f_pri <= frm_pri_in;
            f_ipv4 <= frm_ipv4_in;
            f_proto <= frm_proto_in;
            f_sip <= frm_sip_in;
            f_dip <= frm_dip_in;
            f_sport <= frm_sport_in;
            f_dport <= frm_dport_in;
            f_flags <= frm_flags_in;
            f_tos <= frm_tos_in;
            f_ict <= frm_icmp_type_in;
            f_icc <= frm_icmp_code_in;
        end
    end
    // scan engine and decision
    reg [9:0] dis_set;
    wire [9:0] dis_clr = (wr_go && !pslverr_out && paddr_in == `PLF_A_PORT_DIS) ? pwdata_in[9:0] : 10'h0;
    always @* begin
        dis_set = 10'h0;
        if (state_reg == ST_DONE && best_hit_reg && best_act_reg == `PLF_ACT_SHUT)
            dis_set = port_sel;
    end

    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= ST_IDLE;
            scan_reg <= 3'h0;
            best_hit_reg <= 1'b0;
            best_seq_reg <= 8'h0;
            best_act_reg <= `PLF_ACT_PERMIT;
            frm_ready_out <= 1'b1;
            dec_valid_out <= 1'b0;
            dec_forward_out <= 1'b0;
            dec_drop_out <= 1'b0;
            port_disabled_out <= 10'h0;
        end else begin
            dec_valid_out <= 1'b0;
            port_disabled_out <= (port_disabled_out & ~dis_clr) | dis_set;
            case (state_reg)
                ST_IDLE: begin
                    if (frm_valid_in) begin
                        state_reg <= ST_SCAN;
                        frm_ready_out <= 1'b0;
                        scan_reg <= 3'h0;
                        best_hit_reg <= 1'b0;
                    end
                end
                ST_SCAN: begin
                    if (ent_hit && better) begin
                        best_hit_reg <= 1'b1;
                        best_seq_reg <= w0[`PLF_F_SEQ];
                        best_act_reg <= w0[`PLF_F_ACT];
                    end
                    scan_reg <= scan_reg + 3'h1;
                    if (scan_reg == 3'h7)
                        state_reg <= ST_DONE;
                end
                ST_DONE: begin
                    dec_valid_out <= 1'b1;
                    dec_forward_out <= ~best_hit_reg | (best_act_reg == `PLF_ACT_PERMIT);
                    dec_drop_out <= best_hit_reg & (best_act_reg != `PLF_ACT_PERMIT);
                    frm_ready_out <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                    frm_ready_out <= 1'b1;
                end
            endcase
        end
    end
endmodule // plf_filter
`default_nettype wire

/* test/plf_port_model.sv */
// frame source standing in for a port receive path
`timescale 1ns/1ps
`default_nettype none
module plf_port_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // frame handshake
    input wire logic ready_in,
    output logic valid_out,
    output logic [267:0] hdr_out
);
    logic [267:0] q [$];
    int gap;
    task automatic offer(input logic [267:0] h, input logic [1:0] d);
        q.push_back(h);
        gap = d;
    endtask
    // header toggles while idle so stale fields never pass as valid
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            valid_out <= 1'b0;
            hdr_out <= '1;
        end else if (valid_out && ready_in) begin
            valid_out <= 1'b0;
            hdr_out <= ~hdr_out;
        end else if (!valid_out && q.size() > 0 && gap == 0) begin
            valid_out <= 1'b1;
            hdr_out <= q.pop_front();
        end else if (!valid_out) begin
            hdr_out <= ~hdr_out;
            if (gap > 0) gap <= gap - 1;
        end
    end
endmodule // plf_port_model
`default_nettype wire

/* test/plf_filter_monitor.sv */
// property checker bound to the packet filter ports
`include "plf_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module plf_filter_monitor (
    // clock, reset and apb
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // frames and decisions
    input wire logic frm_valid_in,
    input wire logic frm_ready_out,
    input wire logic dec_valid_out,
    input wire logic dec_forward_out,
    input wire logic dec_drop_out,
    input wire logic [9:0] port_disabled_out
);
    default clocking @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);
    sequence s_setup; psel_in && !penable_in ##1 psel_in && penable_in; endsequence
    sequence s_take; frm_valid_in && frm_ready_out; endsequence
    sequence s_scan; (!dec_valid_out)[*8] ##[1:2] dec_valid_out; endsequence
    property p_apb_answer; s_setup |=> pready_out; endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("apb answer missing");
    property p_pready_pulse; pready_out |-> psel_in && penable_in ##1 !pready_out; endproperty
    a_pready_pulse: assert property (p_pready_pulse) else $error("pready outside access or too long");
    property p_unaligned; psel_in && penable_in && pready_out && paddr_in[1:0] != 2'h0 |-> pslverr_out; endproperty
    a_unaligned: assert property (p_unaligned) else $error("unaligned access not refused");
    property p_take_busy; s_take |=> !frm_ready_out; endproperty
    a_take_busy: assert property (p_take_busy) else $error("ready stayed high after take");
    property p_scan_time; s_take |=> s_scan; endproperty
    a_scan_time: assert property (p_scan_time) else $error("decision timing wrong");
    property p_one_verdict; dec_valid_out |-> dec_forward_out ^ dec_drop_out; endproperty
    a_one_verdict: assert property (p_one_verdict) else $error("verdict not one-hot");
    property p_verdict_hold; !dec_valid_out |-> $stable({dec_forward_out, dec_drop_out}); endproperty
    a_verdict_hold: assert property (p_verdict_hold) else $error("verdict changed between decisions");
    property p_dis_cause;
        |(port_disabled_out & ~$past(port_disabled_out)) |-> dec_valid_out && dec_drop_out;
    endproperty
    a_dis_cause: assert property (p_dis_cause) else $error("port disabled without drop");
    property p_dis_clear;
        |($past(port_disabled_out) & ~port_disabled_out) |->
            $past(psel_in && penable_in && pready_out && pwrite_in && paddr_in == `PLF_A_PORT_DIS);
    endproperty
    a_dis_clear: assert property (p_dis_clear) else $error("port re-enabled without write");
endmodule // plf_filter_monitor
bind plf_filter plf_filter_monitor i_plf_filter_monitor (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .frm_valid_in(frm_valid_in),
    .frm_ready_out(frm_ready_out), .dec_valid_out(dec_valid_out), .dec_forward_out(dec_forward_out),
    .dec_drop_out(dec_drop_out), .port_disabled_out(port_disabled_out));
`default_nettype wire

/* test/plf_filter_bench.sv */
// self-checking bench for the packet filter
`include "plf_regs.vh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module plf_filter_bench;
    typedef struct packed {
        logic [3:0] port; logic [47:0] smac; logic [47:0] dmac; logic [15:0] ety; logic [11:0] vlan;
        logic [2:0] pri; logic ip; logic [7:0] proto; logic [31:0] sip; logic [31:0] dip;
        logic [15:0] sp; logic [15:0] dp; logic [7:0] flg; logic [7:0] tos; logic [7:0] ict; logic [7:0] icc;
    } plf_hdr_t;
    localparam logic [1:0] FW = 2'h2;
    localparam logic [1:0] DR = 2'h1;
    logic clk_sys_in, rst_n_in, psel, penable, pwrite, pready, pslverr, fvalid, fready, dvalid, dfwd, ddrop;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [9:0] pdis;
    logic [267:0] hdr;
    plf_hdr_t f, h;
    logic [31:0] st [10];
    logic [32:0] exp_rd [$];
    logic [1:0] exp_dec [$];
    logic [32:0] e33;
    logic [1:0] e2;
    logic [15:0] spv [4] = '{16'd999, 16'd1000, 16'd2000, 16'd2001};
    logic [1:0] spe [4] = '{FW, DR, DR, FW};
    integer seed = 54938;
    int num_errors = 0, n_tests = 0, cyc = 0;
    assign h = hdr;
    plf_port_model i_plf_port_model (.clk_in(clk_sys_in), .rst_n_in(rst_n_in), .ready_in(fready),
        .valid_out(fvalid), .hdr_out(hdr));
    plf_filter i_plf_filter (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .frm_valid_in(fvalid), .frm_port_in(h.port), .frm_smac_in(h.smac),
        .frm_dmac_in(h.dmac), .frm_etype_in(h.ety), .frm_vlan_in(h.vlan), .frm_pri_in(h.pri), .frm_ipv4_in(h.ip),
        .frm_proto_in(h.proto), .frm_sip_in(h.sip), .frm_dip_in(h.dip), .frm_sport_in(h.sp), .frm_dport_in(h.dp),
        .frm_flags_in(h.flg), .frm_tos_in(h.tos), .frm_icmp_type_in(h.ict), .frm_icmp_code_in(h.icc),
        .frm_ready_out(fready), .dec_valid_out(dvalid), .dec_forward_out(dfwd), .dec_drop_out(ddrop),
        .port_disabled_out(pdis));
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 20000) begin num_errors++; test_done(); end
    end
    // watcher: oldest note against each decision or read answer
    always @(posedge clk_sys_in) begin
        if (dvalid === 1'b1) begin
            e2 = exp_dec.pop_front();
            `CHK({dfwd, ddrop}, e2)
        end
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e33 = exp_rd.pop_front();
            `CHK({pslverr, e33[32] ? 32'h0 : prdata}, e33)
            if (paddr == `PLF_A_PORT_DIS) `CHK(pdis, e33[9:0])
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys_in);
        penable <= 1'b1;
        do @(posedge clk_sys_in); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys_in);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e); exp_rd.push_back(e); apb(1'b0, a, 32'h0); endtask
    function automatic logic [31:0] mk0(input logic ip, input logic [1:0] act, input logic [7:0] sq, input logic [14:0] en);
        return {5'h0, en, sq, ip, act, ip};
    endfunction
    // stage an entry image, then issue the write command
    task automatic load(input logic [2:0] i, input logic [31:0] w0);
        st[0] = w0;
        for (int k = 0; k < `PLF_WORDS; k++) wr(8'(4 * k), st[k]);
        wr(`PLF_A_CMD, {26'h0, `PLF_OP_WRITE, 1'b0, i});
        st = '{default: 32'h0};
    endtask
    task automatic clr(input logic [3:0] p);
        logic [287:0] r;
        for (int k = 0; k < 9; k++) r = {r[255:0], $random(seed)};
        f = r[267:0];
        f.port = p; f.smac[47:24] = 24'h0; f.ety = 16'h0800; f.vlan = 12'h001; f.pri = 3'h0;
        f.ip = 1'b0; f.proto = 8'h00; f.tos = 8'h00;
    endtask
    task automatic send(input logic [1:0] e);
        exp_dec.push_back(e);
        i_plf_port_model.offer(f, 2'($random(seed)));
        do @(posedge clk_sys_in); while (dvalid !== 1'b1);
        @(posedge clk_sys_in);
    endtask
    task automatic tend(input string s); $display("test %s finished", s); endtask
    initial begin
        rst_n_in = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
        st = '{default: 32'h0};
        repeat (12) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        @(posedge clk_sys_in);
        rd(`PLF_A_BIND0, 33'h0);
        rd(`PLF_A_COUNT, 33'h0);
        rd(`PLF_A_PORT_DIS, 33'h0);
        rd(8'h80, 33'h1_0000_0000);
        rd(8'h01, 33'h1_0000_0000);
        tend("reset_map");
        load(3'h0, mk0(1'b0, `PLF_ACT_PERMIT, 8'h05, 15'h0));
        st[1] = 32'hbb00_0000; st[2] = 32'hff00_0000; st[3] = 32'hffff_02aa;
        load(3'h1, mk0(1'b0, `PLF_ACT_DENY, 8'h01, 15'h0001));
        st[7] = 32'h4064_0000; st[8] = 32'h4;
        load(3'h2, mk0(1'b0, `PLF_ACT_DENY, 8'h03, 15'h0018));
        st[4] = 32'hc200_0000; st[5] = 32'hffff_0000; st[6] = 32'hffff_0180; st[7] = 32'h88b5;
        load(3'h3, mk0(1'b0, `PLF_ACT_SHUT, 8'h02, 15'h0006));
        rd(`PLF_A_COUNT, 33'h4);
        wr(`PLF_A_BIND0, 32'h4);
        clr(4'h2); f.smac[47:24] = 24'h02aabb; send(DR);
        clr(4'h2); f.vlan = 12'h064; f.pri = 3'h5; send(DR);
        clr(4'h2); f.vlan = 12'h064; f.pri = 3'h3; send(FW);
        clr(4'h2); f.vlan = 12'h065; f.pri = 3'h7; send(FW);
        clr(4'h3); f.smac[47:24] = 24'h02aabb; send(FW);
        clr(4'h2); f.ety = 16'h88b5; f.dmac[47:16] = 32'h0180_c201; send(FW);
        clr(4'h2); f.ety = 16'h88b5; f.dmac[47:16] = 32'h0180_c200; f.smac[47:24] = 24'h02aabb; send(DR);
        rd(`PLF_A_PORT_DIS, 33'h0);
        clr(4'h2); f.ety = 16'h88b5; f.dmac[47:16] = 32'h0180_c200; send(DR);
        rd(`PLF_A_PORT_DIS, 33'h4);
        clr(4'h2); send(FW);
        rd(`PLF_A_PORT_DIS, 33'h4);
        wr(`PLF_A_PORT_DIS, 32'h4);
        rd(`PLF_A_PORT_DIS, 33'h0);
        tend("mac_list");
        load(3'h1, mk0(1'b0, `PLF_ACT_PERMIT, 8'h01, 15'h0));
        rd(`PLF_A_STATUS, 33'h1);
        load(3'h4, mk0(1'b0, `PLF_ACT_DENY, 8'h06, 15'h0));
        rd(`PLF_A_STATUS, 33'h1);
        wr(`PLF_A_CMD, 32'h30);
        rd(`PLF_A_STATUS, 33'h1);
        wr(`PLF_A_CMD, 32'h21);
        rd(`PLF_A_STATUS, 33'h1);
        rd(`PLF_A_COUNT, 33'h4);
        clr(4'h2); f.smac[47:24] = 24'h02aabb; send(DR);
        wr(`PLF_A_BIND0, 32'h0);
        wr(`PLF_A_CMD, 32'h21);
        rd(`PLF_A_STATUS, 33'h0);
        rd(`PLF_A_COUNT, 33'h3);
        tend("bound_guard");
        st[4] = 32'hc0a8_0100; st[5] = 32'hffff_ff00; st[7] = 32'h0206; st[9] = 32'h0050_0000;
        load(3'h4, mk0(1'b1, `PLF_ACT_DENY, 8'h01, 15'h0522));
        st[7] = 32'h11; st[8] = 32'h300;
        load(3'h5, mk0(1'b1, `PLF_ACT_DENY, 8'h02, 15'h00a0));
        st[7] = 32'h0200_0001;
        load(3'h6, mk0(1'b1, `PLF_ACT_DENY, 8'h03, 15'h6020));
        st[7] = 32'h002e_0000;
        load(3'h7, mk0(1'b1, `PLF_ACT_DENY, 8'h04, 15'h0800));
        st[7] = 32'h0005_0000;
        load(3'h1, mk0(1'b1, `PLF_ACT_DENY, 8'h05, 15'h1000));
        wr(8'h6c, 32'h07d0_03e8);
        wr(`PLF_A_BIND1, 32'h10);
        clr(4'h4); f.ip = 1'b1; f.proto = 8'h06; f.dip = 32'hc0a8_0107; f.dp = 16'd80; f.flg = 8'h12; send(DR);
        f.flg = 8'h10; send(FW);
        f.flg = 8'h12; f.dip = 32'hc0a8_0207; send(FW);
        f.dip = 32'hc0a8_0107; f.dp = 16'd81; send(FW);
        f.sp = 16'd1500; f.flg = 8'h00; send(FW);
        for (int k = 0; k < 4; k++) begin
            clr(4'h4); f.ip = 1'b1; f.proto = 8'h11; f.sp = spv[k]; send(spe[k]);
        end
        clr(4'h4); f.ip = 1'b1; f.proto = 8'h01; f.ict = 8'h08; f.icc = 8'h00; send(DR);
        f.icc = 8'h03; send(FW);
        clr(4'h4); f.ip = 1'b1; f.tos = 8'hb8; send(DR);
        f.tos = 8'ha0; send(DR);
        f.tos = 8'h60; send(FW);
        f.ip = 1'b0; f.tos = 8'hb8; send(FW);
        tend("ipv4_list");
        test_done();
    end
endmodule // plf_filter_bench
`default_nettype wire
